// [verilog/fcc_pkg.sv]
// constants for the feature control register bank
package fcc_pkg;
  // register byte offsets
  localparam logic [11:0] FCC_OFF_BLACK = 12'h0800;
  localparam logic [11:0] FCC_OFF_BAL = 12'h080c;
  localparam logic [11:0] FCC_OFF_MODE = 12'h0900;
  localparam logic [11:0] FCC_OFF_CORR = 12'h0904;
  localparam logic [11:0] FCC_OFF_WB_CORR = 12'h0908;
  // field positions
  localparam int FCC_BIT_PRESENT = 0;
  localparam int FCC_BIT_ABS = 1;
  localparam int FCC_BIT_ONE_SHOT = 5;
  localparam int FCC_BIT_ENABLE = 6;
  localparam int FCC_BIT_AUTO = 7;
  localparam int FCC_LO_LSB = 8;
  localparam int FCC_HI_LSB = 20;
  // reset values
  localparam logic [11:0] FCC_RST_BLACK = 12'h0010;
  localparam logic [11:0] FCC_RST_BLUE = 12'h006a;
  localparam logic [11:0] FCC_RST_RED = 12'h0080;
  localparam logic [2:0] FCC_RST_MODE = 3'h0;
  // value limits
  localparam logic [11:0] FCC_BLACK_MAX = 12'h00ff;
  localparam logic [11:0] FCC_COL_MIN = 12'h0010;
  localparam logic [11:0] FCC_COL_MAX = 12'h00ff;
  localparam logic [11:0] FCC_COL_UNITY = 12'h0040;
  // output formats
  localparam logic [2:0] FCC_FMT_MONO8 = 3'h0;
  localparam logic [2:0] FCC_FMT_RAW8 = 3'h1;
  localparam logic [2:0] FCC_FMT_YUV422 = 3'h2;
  localparam logic [2:0] FCC_FMT_MONO16 = 3'h3;
  localparam logic [2:0] FCC_FMT_RAW16 = 3'h4;
  localparam int FCC_COARSE_SHIFT = 4;
endpackage

// [verilog/fcc_feature_csrs.sv]
// feature control register bank on apb with black-level and colour factor outputs
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module fcc_feature_csrs
  import fcc_pkg::*;
#(
  parameter bit COLOUR_VARIANT = 1'b1
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [11:0] black_level_out,
  output logic [15:0] pixel_offset_out,
  output logic [11:0] blue_level_out,
  output logic [11:0] red_level_out,
  output logic [15:0] blue_factor_out,
  output logic [15:0] red_factor_out
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic setup;
  logic access;
  logic wr_en;
  logic hit;
  logic sel_black;
  logic sel_bal;
  logic sel_mode;
  logic sel_corr;
  logic sel_wb_corr;
  logic [11:0] wr_hi;
  logic [11:0] wr_lo;
  logic [2:0] wr_mode;
  logic [31:0] nxt_rdata;
  logic [11:0] black_ff;
  logic [11:0] blue_ff;
  logic [11:0] red_ff;
  logic [2:0] mode_ff;
  logic [31:0] black_word;
  logic [31:0] bal_word;
  logic [31:0] mode_word;
  logic [31:0] corr_word;
  logic [31:0] wb_corr_word;
  logic nxt_pready;
  logic nxt_pslverr;

  // setup opens a transfer, access is the cycle that ends it
  assign setup = psel_in && !penable_in;
  assign access = psel_in && penable_in;
  // a write lands only at the edge where ready is seen high
  assign wr_en = access && pwrite_in && pready_out;
  assign wr_hi = pwdata_in[FCC_HI_LSB +: 12];
  assign wr_lo = pwdata_in[FCC_LO_LSB +: 12];
  assign wr_mode = pwdata_in[2:0];

  // ----------------------------------------------------------------
  // register selects
  // ----------------------------------------------------------------
  assign sel_black = (paddr_in == FCC_OFF_BLACK);
  assign sel_bal = (paddr_in == FCC_OFF_BAL);
  assign sel_mode = (paddr_in == FCC_OFF_MODE);
  assign sel_corr = (paddr_in == FCC_OFF_CORR);
  assign sel_wb_corr = (paddr_in == FCC_OFF_WB_CORR);
  // any other address answers with an error and no effect
  assign hit = sel_black || sel_bal || sel_mode || sel_corr || sel_wb_corr;

  // ----------------------------------------------------------------
  // read words
  // ----------------------------------------------------------------
  always_comb begin
    black_word = 32'h0000_0000;
    black_word[FCC_BIT_PRESENT] = 1'b1;
    black_word[FCC_BIT_ABS] = 1'b0;
    black_word[FCC_BIT_ONE_SHOT] = 1'b0;
    black_word[FCC_BIT_ENABLE] = 1'b1;
    black_word[FCC_BIT_AUTO] = 1'b0;
    black_word[FCC_HI_LSB +: 12] = black_ff;
  end

  always_comb begin
    bal_word = 32'h0000_0000;
    bal_word[FCC_BIT_PRESENT] = COLOUR_VARIANT;
    bal_word[FCC_BIT_ABS] = 1'b0;
    bal_word[FCC_BIT_ONE_SHOT] = 1'b0;
    bal_word[FCC_BIT_ENABLE] = COLOUR_VARIANT;
    bal_word[FCC_BIT_AUTO] = 1'b0;
    bal_word[FCC_LO_LSB +: 12] = blue_ff;
    bal_word[FCC_HI_LSB +: 12] = red_ff;
  end

  always_comb begin
    mode_word = 32'h0000_0000;
    mode_word[2:0] = mode_ff;
  end

  always_comb begin
    corr_word = 32'h0000_0000;
    corr_word[15:0] = pixel_offset_out;
  end

  always_comb begin
    wb_corr_word = 32'h0000_0000;
    wb_corr_word[15:0] = blue_factor_out;
    wb_corr_word[31:16] = red_factor_out;
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (paddr_in)
      FCC_OFF_BLACK: begin
        nxt_rdata = black_word;
      end
      FCC_OFF_BAL: begin
        nxt_rdata = bal_word;
      end
      FCC_OFF_MODE: begin
        nxt_rdata = mode_word;
      end
      FCC_OFF_CORR: begin
        nxt_rdata = corr_word;
      end
      FCC_OFF_WB_CORR: begin
        nxt_rdata = wb_corr_word;
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // apb answer: no wait state, ready in the first access cycle
  // ----------------------------------------------------------------
  assign nxt_pready = setup;
  assign nxt_pslverr = setup && !hit;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pready_out <= 1'b0;
    end else begin
      pready_out <= nxt_pready;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pslverr_out <= 1'b0;
    end else begin
      pslverr_out <= nxt_pslverr;
    end
  end

  // read data latched in setup, held until the next read
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else begin
      if (setup && !pwrite_in) begin
        prdata_out <= nxt_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // writable fields
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      black_ff <= FCC_RST_BLACK;
    end else if (wr_en && sel_black) begin
      black_ff <= (wr_hi > FCC_BLACK_MAX) ? FCC_BLACK_MAX : wr_hi;
    end
  end

  function automatic logic [11:0] fcc_clamp_col(input logic [11:0] v);
    if (v < FCC_COL_MIN) begin
      return FCC_COL_MIN;
    end else if (v > FCC_COL_MAX) begin
      return FCC_COL_MAX;
    end
    return v;
  endfunction

  logic wr_col;
  assign wr_col = wr_en && sel_bal && COLOUR_VARIANT;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      blue_ff <= FCC_RST_BLUE;
    end else if (wr_col) begin
      blue_ff <= fcc_clamp_col(wr_lo);
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      red_ff <= FCC_RST_RED;
    end else if (wr_col) begin
      red_ff <= fcc_clamp_col(wr_hi);
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_ff <= FCC_RST_MODE;
    end else if (wr_en && sel_mode) begin
      mode_ff <= wr_mode;
    end
  end

  // ----------------------------------------------------------------
  // correction outputs
  // ----------------------------------------------------------------
  logic wide_fmt;
  logic [15:0] nxt_offset;
  assign wide_fmt = (mode_ff == FCC_FMT_MONO16) || (mode_ff == FCC_FMT_RAW16);

  always_comb begin
    if (wide_fmt) begin
      nxt_offset = {4'h0, black_ff};
    end else begin
      nxt_offset = {4'h0, black_ff >> FCC_COARSE_SHIFT};
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pixel_offset_out <= 16'h0000;
    end else begin
      pixel_offset_out <= nxt_offset;
    end
  end

  // ----------------------------------------------------------------
  // level mirrors
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      black_level_out <= 12'h0000;
      blue_level_out <= 12'h0000;
      red_level_out <= 12'h0000;
    end else begin
      black_level_out <= black_ff;
      blue_level_out <= blue_ff;
      red_level_out <= red_ff;
    end
  end

  // ----------------------------------------------------------------
  // colour factors: level over 64, 8.8 fixed point
  // ----------------------------------------------------------------
  logic [15:0] nxt_blue_factor;
  logic [15:0] nxt_red_factor;
  assign nxt_blue_factor = {2'b00, blue_ff, 2'b00};
  assign nxt_red_factor = {2'b00, red_ff, 2'b00};

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      blue_factor_out <= 16'h0000;
      red_factor_out <= 16'h0000;
    end else begin
      blue_factor_out <= nxt_blue_factor;
      red_factor_out <= nxt_red_factor;
    end
  end

endmodule

// [bench/fcc_feature_csrs_properties.sv]
// assertion checker for the feature control register bank
`timescale 1ns/1ps
module fcc_feature_csrs_properties
  import fcc_pkg::*;
#(parameter bit COLOUR_VARIANT = 1'b1) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [11:0] black_level_out,
  input wire logic [15:0] pixel_offset_out,
  input wire logic [11:0] blue_level_out,
  input wire logic [11:0] red_level_out,
  input wire logic [15:0] blue_factor_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  wire rd_ok = pready_out && !pwrite_in;
  a_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready after setup");
  a_ready_one_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  a_unmapped_reads_zero: assert property (rd_ok && pslverr_out |-> prdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_black_fixed_bits: assert property (rd_ok && paddr_in == FCC_OFF_BLACK
    |-> prdata_out[19:0] == 20'h0_0041)
    else $error("black-level fixed bits wrong");
  a_balance_fixed_bits: assert property (rd_ok && paddr_in == FCC_OFF_BAL
    |-> prdata_out[7:0] == {1'b0, COLOUR_VARIANT, 5'h00, COLOUR_VARIANT})
    else $error("balance fixed bits wrong");
  a_black_in_range: assert property (black_level_out <= FCC_BLACK_MAX)
    else $error("black level above limit");
  a_colour_in_range: assert property ($past(reset_n_in) |->
    blue_level_out inside {[FCC_COL_MIN:FCC_COL_MAX]} &&
    red_level_out inside {[FCC_COL_MIN:FCC_COL_MAX]})
    else $error("colour level out of range");
  a_offset_scaling: assert property ($past(reset_n_in) && $stable(black_level_out) |->
    pixel_offset_out == {8'h00, black_level_out[11:4]} ||
    pixel_offset_out == {4'h0, black_level_out})
    else $error("pixel offset not scaled from black level");
  a_blue_factor_scale: assert property ($past(reset_n_in) && $stable(blue_level_out)
    |-> blue_factor_out == {2'b00, blue_level_out, 2'b00})
    else $error("blue factor not level times four");
  cover property (rd_ok && pslverr_out);
  cover property (pready_out && pwrite_in && paddr_in == FCC_OFF_BAL);
  cover property (pready_out && paddr_in == FCC_OFF_MODE);
endmodule

bind fcc_feature_csrs fcc_feature_csrs_properties #(.COLOUR_VARIANT(COLOUR_VARIANT)) u_props (
  .core_clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .prdata_out,
  .pready_out, .pslverr_out, .black_level_out, .pixel_offset_out, .blue_level_out,
  .red_level_out, .blue_factor_out);

// [bench/fcc_feature_csrs_test.sv]
// self-checking testbench for the feature control register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module fcc_feature_csrs_test
  import fcc_pkg::*;
;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, rd;
  logic pready_out, pslverr_out, se;
  logic [11:0] black_level_out, blue_level_out, red_level_out;
  logic [15:0] pixel_offset_out, blue_factor_out, red_factor_out;
  int err_total = 0, check_count = 0;
  always #12.5 core_clk_in = ~core_clk_in;
  fcc_feature_csrs uut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .black_level_out(black_level_out),
    .pixel_offset_out(pixel_offset_out), .blue_level_out(blue_level_out),
    .red_level_out(red_level_out), .blue_factor_out(blue_factor_out),
    .red_factor_out(red_factor_out));
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge core_clk_in);
    psel_in <= 1'b1; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    for (n = 0; n < 50 && pready_out !== 1'b1; n++) @(posedge core_clk_in);
    if (n == 50) err_total++;
    rd = prdata_out; se = pslverr_out;
    psel_in <= 1'b0; penable_in <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0000_0000);
    `CHK("read data", e, rd)
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #100us;
    err_total++;
    finish_test;
  end
  initial begin
    repeat (5) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    rdc(FCC_OFF_BLACK, 32'h0100_0041);
    rdc(FCC_OFF_BAL, 32'h0800_6a41);
    xfer(FCC_OFF_BLACK, 1'b1, 32'h0fff_ffbe);
    rdc(FCC_OFF_BLACK, 32'h0ff0_0041);
    xfer(FCC_OFF_BLACK, 1'b1, 32'h0200_0000);
    for (int m = 0; m < 8; m++) begin
      xfer(FCC_OFF_MODE, 1'b1, 32'(m));
      repeat (3) @(posedge core_clk_in);
      `CHK("offset", (m == 3 || m == 4) ? 16'h0020 : 16'h0002, pixel_offset_out)
    end
    rdc(FCC_OFF_MODE, 32'h0000_0007);
    rdc(FCC_OFF_CORR, 32'h0000_0002);
    `CHK("black", 12'h020, black_level_out)
    xfer(FCC_OFF_BAL, 1'b1, 32'h0400_4000);
    repeat (3) @(posedge core_clk_in);
    `CHK("blue level", 12'h040, blue_level_out)
    `CHK("red level", 12'h040, red_level_out)
    `CHK("blue factor", 16'h0100, blue_factor_out)
    `CHK("red factor", 16'h0100, red_factor_out)
    rdc(FCC_OFF_WB_CORR, 32'h0100_0100);
    xfer(FCC_OFF_BAL, 1'b1, 32'hffff_ffff);
    rdc(FCC_OFF_BAL, 32'h0ff0_ff41);
    xfer(12'h0a00, 1'b0, 32'h0000_0000);
    `CHK("error flag", 1'b1, se)
    `CHK("unmapped data", 32'h0000_0000, rd)
    finish_test;
  end
endmodule
